/* src/pti_pkg.sv */
// Package: register map, field layout, reset values and timing for the proximity interrupt
package pti_pkg;
   // Register indexes; byte address is four times the index
   localparam logic [7:0] IDX_CONF   = 8'h00;
   localparam logic [7:0] IDX_LOWER  = 8'h04;
   localparam logic [7:0] IDX_UPPER  = 8'h05;
   localparam logic [7:0] IDX_TIMING = 8'h06;
   localparam logic [7:0] IDX_IDLE   = 8'h07;
   localparam logic [7:0] IDX_DATA   = 8'hF8;
   localparam logic [7:0] IDX_FLAG   = 8'hF9;

   // Configuration field positions
   localparam int MODE_HI     = 15;
   localparam int MODE_LO     = 14;
   localparam int PERS_HI     = 13;
   localparam int PERS_LO     = 12;
   localparam int RAPID_BIT   = 11;
   localparam int SAT_EN_BIT  = 10;
   localparam int FIRST_EN_BIT = 9;
   localparam int SHUTDOWN_BIT = 0;

   // Event flag positions
   localparam int FIRST_FLAG_BIT = 11;
   localparam int SAT_FLAG_BIT   = 10;
   localparam int NEAR_FLAG_BIT  = 9;
   localparam int FAR_FLAG_BIT   = 8;

   // Interrupt modes
   typedef enum logic [1:0] {
      MODE_OFF   = 2'h0,
      MODE_LEVEL = 2'h1,
      MODE_FIRST = 2'h2,
      MODE_EACH  = 2'h3
   } pti_mode_t;

   // Values after reset
   localparam logic [1:0]  RST_MODE     = 2'h0;
   localparam logic [1:0]  RST_PERS     = 2'h0;
   localparam logic [15:0] RST_LOWER    = 16'h0000;
   localparam logic [15:0] RST_UPPER    = 16'hFFFF;
   localparam logic [7:0]  RST_AMBIENT  = 8'h10;
   localparam logic [7:0]  RST_PULSE    = 8'h08;
   localparam logic [15:0] RST_IDLE     = 16'h0064;

   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int US_NS         = 1000;
   localparam int US_CYC        = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RAPID_GAP_US  = 1400;
   localparam logic [1:0] CONFIRM_MEAS = 2'h3;
endpackage

/* src/pti_top.sv */
// Proximity threshold interrupt: persistence filter, measurement pacing and Wishbone registers
`timescale 1ns/10ps
// Summary of operation
// - Three interrupt modes: level, first-high, each-event
// - Level mode: line low above upper limit
// - Level mode: line high below lower limit
// - Count equal to a limit never crosses
// - Level mode: near and far events alternate
// - Level mode: line itself shows near state
// - Flag modes: either crossing pulls line low
// - Flag modes: first event may be either
// - Crossings set near or far flag
// - Reading event flags clears near and far
// - First-high mode repeats same-kind events
// - Programmable consecutive crossings needed, all modes
// - Persistence above one with rapid confirm: three confirming measurements
// - Assert when consecutive count reaches setting
// - Period is idle plus ambient plus twice pulse
// - Rapid confirm: three measurements 1.4 ms apart
// - Rapid confirm honours persistence count too
// - Saturation reports a zero count
// - Saturation flag and interrupt when enabled
// - First result after shutdown release interrupts
// - Reading event flags clears first-result flag
// - Mode field bits 15:14, default off
// - Persistence field bits 13:12, default one
// - Flags at bits 11, 10, 9, 8
module pti_top
   import pti_pkg::*;
#(
   parameter int RAPID_GAP_US_P = RAPID_GAP_US,
   parameter int US_CYC_P       = US_CYC
) (
   input  wire logic        clk_in,           // 20 MHz clock
   input  wire logic        rst_n_in,         // Async reset, active low
   input  wire logic        wb_cyc_in,        // Wishbone cycle
   input  wire logic        wb_stb_in,        // Wishbone strobe
   input  wire logic        wb_we_in,         // Wishbone write enable
   input  wire logic [9:0]  wb_adr_in,        // Wishbone byte address
   input  wire logic [3:0]  wb_sel_in,        // Wishbone byte lanes
   input  wire logic [31:0] wb_dat_in,        // Wishbone write data
   output logic      [31:0] wb_dat_out,       // Wishbone read data
   output logic             wb_ack_out,       // Wishbone acknowledge
   input  wire logic [15:0] afe_count_in,     // Raw count of the front end
   input  wire logic        afe_saturated_in, // Photodiode saturated
   output logic             meas_done_out,    // Measurement completed pulse
   output logic      [15:0] count_result_out, // Latest count result
   output logic             irq_n_out         // Interrupt line, active low
);

   typedef enum logic {SEQ_OFF, SEQ_RUN} pti_seq_t;

   typedef struct packed {
      pti_seq_t    seq;
      logic [15:0] us_div;
      logic [17:0] tick_cnt;
      logic [1:0]  rapid_left;
      logic        near_state;
      logic [2:0]  hi_cnt;
      logic [2:0]  lo_cnt;
      logic        sat_prev;
      logic        first_pending;
      logic [1:0]  irq_mode_select;
      logic [1:0]  crossing_count_setting;
      logic        rapid_confirm_enable;
      logic        saturation_irq_enable;
      logic        first_result_irq_enable;
      logic        sensor_shutdown;
      logic [15:0] lower_limit;
      logic [15:0] upper_limit;
      logic [7:0]  ambient_sample_phase;
      logic [7:0]  pulse_integration_time;
      logic [15:0] idle_interval;
      logic [15:0] count_result;
      logic        first_result_flag;
      logic        saturation_flag;
      logic        near_crossing_flag;
      logic        far_crossing_flag;
      logic        ack;
      logic [31:0] dat;
      logic        done;
      logic        irq_n;
   } pti_state_t;

   pti_state_t s;
   pti_state_t n;

   localparam logic [15:0] US_DIV_MAX = 16'(US_CYC_P - 1);
   localparam logic [17:0] RAPID_GAP  = 18'(RAPID_GAP_US_P);

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = wd[7:0];
      end
      if (sel[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   logic        req;
   logic        us_tick;
   logic [17:0] active_us;
   logic [17:0] period_us;
   logic [15:0] cnt;
   logic        hi;
   logic        lo;
   logic [2:0]  need;
   logic [2:0]  hi_inc;
   logic [2:0]  lo_inc;
   logic        hi_ev;
   logic        lo_ev;
   logic [15:0] wr_val;
   logic [7:0]  idx;
   logic        thr_pend;
   logic [15:0] conf_rd;
   logic [15:0] flag_rd;

   // Next-state logic for the whole block
   always_comb begin
      n = s;
      n.ack = 1'b0;
      n.done = 1'b0;
      idx = wb_adr_in[9:2];
      req = wb_cyc_in && wb_stb_in && !s.ack;
      us_tick = (s.us_div == US_DIV_MAX);
      n.us_div = us_tick ? 16'h0000 : s.us_div + 16'h0001;
      active_us = 18'(s.ambient_sample_phase) + 18'({s.pulse_integration_time, 1'b0});
      period_us = (s.rapid_left != 2'h0) ? RAPID_GAP + active_us
                                         : 18'(s.idle_interval) + active_us;
      cnt = afe_saturated_in ? 16'h0000 : afe_count_in;
      hi = (cnt > s.upper_limit);
      lo = (cnt < s.lower_limit);
      need = {1'b0, s.crossing_count_setting} + 3'h1;
      hi_inc = s.hi_cnt + 3'h1;
      lo_inc = s.lo_cnt + 3'h1;
      hi_ev = 1'b0;
      lo_ev = 1'b0;
      conf_rd = {s.irq_mode_select, s.crossing_count_setting, s.rapid_confirm_enable,
                 s.saturation_irq_enable, s.first_result_irq_enable, 8'h00,
                 s.sensor_shutdown};
      flag_rd = 16'h0000;
      flag_rd[FIRST_FLAG_BIT] = s.first_result_flag;
      flag_rd[SAT_FLAG_BIT] = s.saturation_flag;
      flag_rd[NEAR_FLAG_BIT] = s.near_crossing_flag;
      flag_rd[FAR_FLAG_BIT] = s.far_crossing_flag;
      wr_val = 16'h0000;

      // Register access; clears come first so a same-cycle event wins
      if (req) begin
         n.ack = 1'b1;
         n.dat = 32'h0000_0000;
         if (wb_we_in) begin
            unique case (idx)
               IDX_CONF: begin
                  wr_val = merge16(conf_rd, wb_dat_in, wb_sel_in);
                  n.irq_mode_select = wr_val[MODE_HI:MODE_LO];
                  n.crossing_count_setting = wr_val[PERS_HI:PERS_LO];
                  n.rapid_confirm_enable = wr_val[RAPID_BIT];
                  n.saturation_irq_enable = wr_val[SAT_EN_BIT];
                  n.first_result_irq_enable = wr_val[FIRST_EN_BIT];
                  n.sensor_shutdown = wr_val[SHUTDOWN_BIT];
               end
               IDX_LOWER: n.lower_limit = merge16(s.lower_limit, wb_dat_in, wb_sel_in);
               IDX_UPPER: n.upper_limit = merge16(s.upper_limit, wb_dat_in, wb_sel_in);
               IDX_TIMING: begin
                  wr_val = merge16({s.pulse_integration_time, s.ambient_sample_phase},
                                   wb_dat_in, wb_sel_in);
                  n.ambient_sample_phase = wr_val[7:0];
                  n.pulse_integration_time = wr_val[15:8];
               end
               IDX_IDLE: n.idle_interval = merge16(s.idle_interval, wb_dat_in, wb_sel_in);
               default: ;
            endcase
         end else begin
            unique case (idx)
               IDX_CONF:   n.dat = {16'h0000, conf_rd};
               IDX_LOWER:  n.dat = {16'h0000, s.lower_limit};
               IDX_UPPER:  n.dat = {16'h0000, s.upper_limit};
               IDX_TIMING: n.dat = {16'h0000, s.pulse_integration_time, s.ambient_sample_phase};
               IDX_IDLE:   n.dat = {16'h0000, s.idle_interval};
               IDX_DATA:   n.dat = {16'h0000, s.count_result};
               IDX_FLAG: begin
                  n.dat = {16'h0000, flag_rd};
                  n.near_crossing_flag = 1'b0;
                  n.far_crossing_flag = 1'b0;
                  n.first_result_flag = 1'b0;
                  n.saturation_flag = 1'b0;
               end
               default: n.dat = 32'h0000_0000;
            endcase
         end
      end

      // Measurement pacing on microsecond ticks
      unique case (s.seq)
         SEQ_OFF: begin
            if (!s.sensor_shutdown) begin
               n.seq = SEQ_RUN;
               n.tick_cnt = 18'h00000;
               n.first_pending = 1'b1;
            end
         end
         SEQ_RUN: begin
            if (s.sensor_shutdown) begin
               // Shutdown drops all filter state so restart is clean
               n.seq = SEQ_OFF;
               n.rapid_left = 2'h0;
               n.hi_cnt = 3'h0;
               n.lo_cnt = 3'h0;
               n.near_state = 1'b0;
               n.first_pending = 1'b0;
            end else if (us_tick) begin
               if (s.tick_cnt + 18'h00001 >= period_us) begin
                  n.tick_cnt = 18'h00000;
                  n.done = 1'b1;
               end else begin
                  n.tick_cnt = s.tick_cnt + 18'h00001;
               end
            end
         end
      endcase

      // Evaluation of each completed measurement
      if (n.done) begin
         n.count_result = cnt;
         n.sat_prev = afe_saturated_in;
         if (s.rapid_left != 2'h0) begin
            n.rapid_left = s.rapid_left - 2'h1;
         end
         // Start of a crossing run opens the confirming window
         if ((hi || lo) && s.hi_cnt == 3'h0 && s.lo_cnt == 3'h0 &&
             s.crossing_count_setting != 2'h0 && s.rapid_confirm_enable) begin
            n.rapid_left = CONFIRM_MEAS;
         end
         // Consecutive counters; a non-crossing measurement restarts them
         n.hi_cnt = hi ? ((s.hi_cnt >= need) ? need : hi_inc) : 3'h0;
         n.lo_cnt = lo ? ((s.lo_cnt >= need) ? need : lo_inc) : 3'h0;
         hi_ev = hi && (hi_inc == need);
         lo_ev = lo && (lo_inc == need);
         unique case (pti_mode_t'(s.irq_mode_select))
            MODE_OFF: begin
               hi_ev = 1'b0;
               lo_ev = 1'b0;
               n.near_state = 1'b0;
            end
            MODE_LEVEL: begin
               hi_ev = hi_ev && !s.near_state;
               lo_ev = lo_ev && s.near_state;
               if (hi_ev) begin
                  n.near_state = 1'b1;
               end
               if (lo_ev) begin
                  n.near_state = 1'b0;
               end
            end
            MODE_FIRST: begin
               // Restarting the run lets the same kind fire again
               if (hi_ev) begin
                  n.hi_cnt = 3'h0;
               end
               if (lo_ev) begin
                  n.lo_cnt = 3'h0;
               end
            end
            MODE_EACH: ;
         endcase
         // Either direction may come first in the flag modes
         if (hi_ev) begin
            n.near_crossing_flag = 1'b1;
         end
         if (lo_ev) begin
            n.far_crossing_flag = 1'b1;
         end
         if (afe_saturated_in && !s.sat_prev && s.saturation_irq_enable) begin
            n.saturation_flag = 1'b1;
         end
         if (s.first_pending) begin
            n.first_pending = 1'b0;
            if (s.first_result_irq_enable) begin
               n.first_result_flag = 1'b1;
            end
         end
      end

      // Interrupt line from the settled next state
      if (pti_mode_t'(n.irq_mode_select) == MODE_LEVEL) begin
         thr_pend = n.near_state;
      end else if (pti_mode_t'(n.irq_mode_select) == MODE_OFF) begin
         thr_pend = 1'b0;
      end else begin
         thr_pend = n.near_crossing_flag || n.far_crossing_flag;
      end
      n.irq_n = !(thr_pend || (n.saturation_flag && n.saturation_irq_enable) ||
                  (n.first_result_flag && n.first_result_irq_enable));
   end

   // State register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s <= '0;
         s.seq <= SEQ_OFF;
         s.irq_mode_select <= RST_MODE;
         s.crossing_count_setting <= RST_PERS;
         s.sensor_shutdown <= 1'b1;
         s.lower_limit <= RST_LOWER;
         s.upper_limit <= RST_UPPER;
         s.ambient_sample_phase <= RST_AMBIENT;
         s.pulse_integration_time <= RST_PULSE;
         s.idle_interval <= RST_IDLE;
         s.irq_n <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // Outputs straight from the state register
   assign wb_dat_out = s.dat;
   assign wb_ack_out = s.ack;
   assign meas_done_out = s.done;
   assign count_result_out = s.count_result;
   assign irq_n_out = s.irq_n;

endmodule

/* bench/pti_properties.sv */
// Port checker for the proximity threshold interrupt
`timescale 1ns/10ps
module pti_checker (
   input wire logic        clk_in,           // Clock
   input wire logic        rst_n_in,         // Reset, active low
   input wire logic        wb_cyc_in,        // Cycle
   input wire logic        wb_stb_in,        // Strobe
   input wire logic        wb_ack_out,       // Acknowledge
   input wire logic [31:0] wb_dat_out,       // Read data
   input wire logic [15:0] afe_count_in,     // Raw count
   input wire logic        afe_saturated_in, // Saturation
   input wire logic        meas_done_out,    // Measurement done
   input wire logic [15:0] count_result_out, // Count result
   input wire logic        irq_n_out         // Interrupt line
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Bus answers
   a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("request not acknowledged");
   a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
      else $error("ack without request");
   a_upper_zero: assert property (wb_ack_out |-> wb_dat_out[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   // Measurement results
   a_count_value: assert property (meas_done_out |-> count_result_out ==
      ($past(afe_saturated_in) ? 16'h0000 : $past(afe_count_in)))
      else $error("count result wrong");
   a_count_hold: assert property (!meas_done_out && $past(rst_n_in) |-> $stable(count_result_out))
      else $error("count changed without measurement");
   a_done_pulse: assert property (meas_done_out |=> !meas_done_out [*4])
      else $error("done pulse too long or too close");
   // The line moves only on a measurement or a register access
   a_irq_fall: assert property ($fell(irq_n_out) |-> meas_done_out)
      else $error("interrupt without measurement");
   a_irq_rise: assert property ($rose(irq_n_out) |->
      meas_done_out || wb_ack_out || $past(wb_ack_out) || !$past(rst_n_in))
      else $error("interrupt released without cause");
endmodule
bind pti_top pti_checker i_pti_checker (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
   .wb_dat_out(wb_dat_out), .afe_count_in(afe_count_in), .afe_saturated_in(afe_saturated_in),
   .meas_done_out(meas_done_out), .count_result_out(count_result_out), .irq_n_out(irq_n_out));

/* bench/pti_host_model.sv */
// Host model: Wishbone master reading and writing the sensor registers
`timescale 1ns/10ps
module pti_host_model (
   input  wire logic        clk_in,  // Clock
   input  wire logic        ack_in,  // Slave acknowledge
   input  wire logic [31:0] dat_in,  // Slave read data
   output logic             cyc_out, // Cycle
   output logic             stb_out, // Strobe
   output logic             we_out,  // Write enable
   output logic      [9:0]  adr_out, // Byte address
   output logic      [3:0]  sel_out, // Byte lanes
   output logic      [31:0] dat_out  // Write data
);
   // Idle bus at time zero
   initial begin
      cyc_out = 1'b0;
      stb_out = 1'b0;
      we_out = 1'b0;
      adr_out = 10'h000;
      sel_out = 4'h0;
      dat_out = 32'h00000000;
   end
   // One classic cycle; leading edge keeps strobe low a cycle between cycles
   task automatic xfer(input logic w, input logic [9:0] a, input logic [15:0] d,
                       output logic [15:0] q);
      @(posedge clk_in);
      cyc_out <= 1'b1;
      stb_out <= 1'b1;
      we_out <= w;
      adr_out <= a;
      sel_out <= 4'h3;
      dat_out <= {16'h0000, d};
      do @(posedge clk_in); while (ack_in !== 1'b1);
      q = dat_in[15:0];
      cyc_out <= 1'b0;
      stb_out <= 1'b0;
      we_out <= 1'b0;
   endtask
endmodule

/* bench/testbench.sv */
// Self-checking bench for the proximity threshold interrupt
`timescale 1ns/10ps
module testbench;
   import pti_pkg::*;
   logic        clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        cyc, stb, we, ack, done, irq_n;
   logic        sat = 1'b0;
   logic [9:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   logic [15:0] cnt = 16'h0000;
   logic [15:0] res;
   int          fail_count = 0;
   int          checks_done = 0;
   int          n;
   // Clock of 50 ns
   always #25 clk_in = ~clk_in;
   pti_top #(.RAPID_GAP_US_P(5), .US_CYC_P(2)) i_pti_top (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
      .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .afe_count_in(cnt),
      .afe_saturated_in(sat), .meas_done_out(done), .count_result_out(res), .irq_n_out(irq_n));
   pti_host_model i_pti_host_model (.clk_in(clk_in), .ack_in(ack), .dat_in(rdat), .cyc_out(cyc),
      .stb_out(stb), .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wdat));
   // Shared compare, register access and measurement steps
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [15:0] d);
      logic [15:0] q;
      i_pti_host_model.xfer(1'b1, {idx, 2'b00}, d, q);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
      logic [15:0] q;
      i_pti_host_model.xfer(1'b0, {idx, 2'b00}, 16'h0000, q);
      chk(q, exp, "register read");
   endtask
   // Inputs change after an edge; done and line are sampled at the edge after done rose
   task automatic meas(input logic [15:0] c, input logic s, input logic ei, output int k);
      @(posedge clk_in);
      cnt <= c;
      sat <= s;
      k = 0;
      do begin
         @(posedge clk_in);
         k++;
      end while (done !== 1'b1 && k < 400);
      // A measurement that never completes is a mismatch of its own
      if (k >= 400) begin
         fail_count++;
         $display("[FAIL] %0t measurement did not complete", $time);
      end
      chk({15'h0000, irq_n}, {15'h0000, ei}, "interrupt line");
      chk(res, s ? 16'h0000 : c, "count result");
   endtask
   task automatic t_regs;
      rd(IDX_CONF, 16'h0001);
      rd(IDX_UPPER, RST_UPPER);
      rd(IDX_FLAG, 16'h0000);
      wr(8'hFF, 16'h1234);
      rd(8'hFF, 16'h0000);
      wr(IDX_DATA, 16'h1234);
      rd(IDX_DATA, 16'h0000);
      wr(IDX_LOWER, 16'h0064);
      wr(IDX_UPPER, 16'h00C8);
      wr(IDX_TIMING, 16'h0101);
      wr(IDX_IDLE, 16'h0014);
      rd(IDX_UPPER, 16'h00C8);
      $display("test registers done");
   endtask
   // Each-event mode, first result and saturation
   task automatic t_each;
      wr(IDX_CONF, 16'hC200);
      meas(16'd150, 1'b0, 1'b0, n);
      rd(IDX_FLAG, 16'h0800);
      meas(16'd100, 1'b0, 1'b1, n);
      meas(16'd99, 1'b0, 1'b0, n);
      rd(IDX_FLAG, 16'h0100);
      meas(16'd200, 1'b0, 1'b1, n);
      meas(16'd201, 1'b0, 1'b0, n);
      rd(IDX_FLAG, 16'h0200);
      meas(16'd201, 1'b0, 1'b1, n);
      wr(IDX_CONF, 16'h0400);
      meas(16'd150, 1'b1, 1'b0, n);
      rd(IDX_FLAG, 16'h0400);
      meas(16'd150, 1'b0, 1'b1, n);
      $display("test each-event done");
   endtask
   task automatic t_first;
      wr(IDX_CONF, 16'h8000);
      meas(16'd201, 1'b0, 1'b0, n);
      rd(IDX_FLAG, 16'h0200);
      meas(16'd201, 1'b0, 1'b0, n);
      rd(IDX_FLAG, 16'h0200);
      meas(16'd150, 1'b0, 1'b1, n);
      $display("test first-high done");
   endtask
   task automatic t_level;
      wr(IDX_CONF, 16'h0001);
      wr(IDX_CONF, 16'h4000);
      meas(16'd201, 1'b0, 1'b0, n);
      rd(IDX_FLAG, 16'h0200);
      meas(16'd201, 1'b0, 1'b0, n);
      rd(IDX_FLAG, 16'h0000);
      meas(16'd99, 1'b0, 1'b1, n);
      rd(IDX_FLAG, 16'h0100);
      $display("test level done");
   endtask
   // Persistence of two, then three with rapid confirmation
   task automatic t_pers;
      wr(IDX_CONF, 16'h0001);
      wr(IDX_CONF, 16'h5000);
      meas(16'd201, 1'b0, 1'b1, n);
      meas(16'd201, 1'b0, 1'b0, n);
      chk(16'(n + 1), 16'd46, "regular period");
      wr(IDX_CONF, 16'h0001);
      wr(IDX_CONF, 16'h6800);
      meas(16'd150, 1'b0, 1'b1, n);
      meas(16'd201, 1'b0, 1'b1, n);
      meas(16'd201, 1'b0, 1'b1, n);
      chk(16'(n + 1), 16'd16, "rapid gap");
      meas(16'd201, 1'b0, 1'b0, n);
      meas(16'd201, 1'b0, 1'b0, n);
      chk(16'(n + 1), 16'd16, "rapid gap");
      meas(16'd201, 1'b0, 1'b0, n);
      chk(16'(n + 1), 16'd46, "period after rapid");
      $display("test persistence done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_regs;
      t_each;
      t_first;
      t_level;
      t_pers;
      finish_test;
   end
   // Watchdog well above the expected run of about a thousand cycles
   initial begin
      repeat (20000) @(posedge clk_in);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      finish_test;
   end
endmodule
